// file: design/vbr_recon.sv
// Reconstruction path: vector prediction, half-pixel interpolation,
// dequantisation with zigzag placement, inverse transform and summation.
// Assumes a parser feeding coefficients and vectors and a frame memory that
// supplies prediction pixels and neighbours; all on one clock.
// Function
// R1: Predictor is median of three candidates.
// R2: Border checks applied in fixed order.
// R3: Intra or uncoded neighbour gives zero candidate. The code zeroes an intra neighbour only when bidir_pair is low.
// R4: Left candidate zero outside picture or slice.
// R5: Above candidates copy left when above outside.
// R6: Above-right zero beyond right picture edge.
// R7: Pick difference alternative keeping vector in range.
// R8: Positive components point right or down.
// R9: One vector serves all four luma blocks.
// R10: Chroma vector halved, quarters become half.
// R11: Bilinear interpolation with truncating division.
// R12: Rounding control from flag when extended type.
// R13: Rounding control zero for block-pair B-part.
// R14: Half samples add one or two minus rounding.
// R15: Zero level reconstructs to zero.
// R16: Magnitude is quantizer times odd level term.
// R17: Level sign applied to magnitude.
// R18: Coefficients saturate to twelve signed bits.
// R19: Coefficients placed by zigzag order.
// R20: Separable inverse transform, output nine bits.
// R21: Transform arithmetic kept close to tolerance.
// R22: Intra uses transform only; inter adds prediction.
// R23: Summed pixels saturate to 0..255.
// R24: Single clock, synchronous reset, valid/ready stages.
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
module vbr_recon
	import vbr_pkg::*;
#(
	parameter logic [2:0] EXT_FORMAT_CODE = 3'h7
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic mv_in_valid,
	input wire vbr_mv_req_s mv_in,
	output logic mv_in_ready,
	output logic mv_out_valid,
	output vbr_mv_res_s mv_out,
	input wire logic mv_out_ready,
	input wire logic ip_in_valid,
	input wire vbr_ip_req_s ip_in,
	output logic ip_in_ready,
	output logic ip_out_valid,
	output logic [7:0] ip_out,
	input wire logic ip_out_ready,
	output logic rounding_control,
	input wire logic cf_in_valid,
	input wire vbr_coef_s cf_in,
	output logic cf_in_ready,
	input wire logic pred_valid,
	input wire logic [7:0] pred_pixel,
	output logic pred_ready,
	output logic px_out_valid,
	output vbr_pix_s px_out,
	input wire logic px_out_ready
);

	typedef struct packed {
		logic [15:0] pictype;
		logic [15:0] exttype;
		logic bpart;
		logic rc;
		logic wait_req;
		logic [31:0] rdata;
		logic mv_in_rdy;
		logic mv_out_vld;
		vbr_mv_res_s mv_res;
		logic ip_in_rdy;
		logic ip_out_vld;
		logic [7:0] ip_res;
		vbr_state_e fsm;
		logic cf_rdy;
		logic intra;
		logic [5:0] idx;
		logic [2:0] k;
		logic signed [35:0] acc;
		logic [63:0][11:0] coef;
		logic [63:0][17:0] tmp;
		logic pred_rdy;
		logic px_vld;
		vbr_pix_s px;
	} vbr_st_s;

	vbr_st_s st_reg;
	vbr_st_s st_next;

	function automatic logic zero_cand(input vbr_cand_s c, input logic bidir);
		return (c.intra && !bidir) || c.mb_not_coded_flag;
	endfunction

	function automatic logic signed [6:0] med3(input logic signed [6:0] a,
		input logic signed [6:0] b, input logic signed [6:0] c);
		logic signed [6:0] lo;
		logic signed [6:0] hi;
		lo = (a < b) ? a : b;
		hi = (a < b) ? b : a;
		hi = (hi < c) ? hi : c;
		return (lo > hi) ? lo : hi;
	endfunction

	// Each code has two values 64 half-pixels apart; only one lands in range.
	function automatic logic signed [6:0] mv_wrap(input logic signed [6:0] p,
		input logic signed [6:0] d);
		logic signed [7:0] s;
		s = {p[6], p} + {d[6], d};
		if (s > VBR_MV_MAX) begin
			s = s - VBR_MV_WRAP;
		end else if (s < VBR_MV_MIN) begin
			s = s + VBR_MV_WRAP;
		end
		return s[6:0];
	endfunction

	// Halving a half-pixel value gives quarter steps; any quarter goes to half.
	function automatic logic signed [6:0] mv_chroma(input logic signed [6:0] v);
		logic signed [6:0] q;
		q = v >>> 2;
		return {q[5:0], |v[1:0]};
	endfunction

	function automatic logic signed [15:0] kern(input logic [2:0] n, input logic [2:0] u);
		logic [6:0] m;
		logic [4:0] r;
		logic [14:0] mag;
		logic neg;
		logic signed [15:0] kv;
		m = 7'((7'(n) * 7'h2 + 7'h1) * 7'(u));
		r = m[4:0];
		neg = 1'b0;
		if (r > 5'h10) begin
			r = 5'(6'h20 - 6'(r));
		end
		if (r > 5'h08) begin
			neg = 1'b1;
			mag = VBR_COS_HALF[4'(5'h10 - r)];
		end else begin
			mag = VBR_COS_HALF[r[3:0]];
		end
		if (u == 3'h0) begin
			mag = VBR_COS_DC;
		end
		kv = $signed({1'b0, mag});
		return neg ? -kv : kv;
	endfunction

	function automatic logic [5:0] raster_of(input logic [5:0] z);
		logic [5:0] r;
		r = 6'h00;
		for (int i = 0; i < 64; i++) begin
			if (VBR_ZZ_OF_RASTER[i] == z) begin
				r = 6'(i);
			end
		end
		return r;
	endfunction

	function automatic logic [15:0] be16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	always_comb begin
		vbr_vec_s c1;
		vbr_vec_s c2;
		vbr_vec_s c3;
		vbr_vec_s luma;
		logic top_out;
		logic [9:0] isum;
		logic [7:0] mag;
		logic [13:0] recm;
		logic signed [14:0] recs;
		logic signed [35:0] term;
		logic signed [35:0] accn;
		logic signed [35:0] scaled;
		logic signed [12:0] psum;
		logic take;
		vbr_st_s n;
		c1 = '0;
		c2 = '0;
		c3 = '0;
		luma = '0;
		top_out = 1'b0;
		isum = 10'h000;
		mag = 8'h00;
		recm = 14'h0000;
		recs = 15'sh0000;
		term = '0;
		accn = '0;
		scaled = '0;
		psum = '0;
		take = 1'b0;
		n = st_reg;

		// Register slave: one wait cycle, then a single-cycle answer.
		n.wait_req = 1'b1;
		if ((avs_read || avs_write) && st_reg.wait_req) begin
			n.wait_req = 1'b0;
			n.rdata = 32'h00000000;
			if (avs_address == VBR_OFS_PICTYPE) begin
				n.rdata = {16'h0000, st_reg.pictype};
			end else if (avs_address == VBR_OFS_EXTTYPE) begin
				n.rdata = {16'h0000, st_reg.exttype};
			end else if (avs_address == VBR_OFS_MODE) begin
				n.rdata[VBR_BPART_BIT] = st_reg.bpart;
			end else if (avs_address == VBR_OFS_STATUS) begin
				n.rdata[VBR_ST_RC_BIT] = st_reg.rc;
				n.rdata[VBR_ST_BUSY_BIT] = (st_reg.fsm != VBR_S_COLLECT);
			end
		end
		if (avs_write && !st_reg.wait_req) begin
			if (avs_address == VBR_OFS_PICTYPE) begin
				n.pictype = be16(st_reg.pictype, avs_writedata, avs_byteenable);
			end else if (avs_address == VBR_OFS_EXTTYPE) begin
				n.exttype = be16(st_reg.exttype, avs_writedata, avs_byteenable);
			end else if (avs_address == VBR_OFS_MODE && avs_byteenable[0]) begin
				n.bpart = avs_writedata[VBR_BPART_BIT];
			end
		end
		n.rc = 1'b0;
		if (st_reg.pictype[VBR_SRCFMT_LSB +: VBR_SRCFMT_W] == EXT_FORMAT_CODE) begin
			n.rc = st_reg.exttype[VBR_ROUNDING_TYPE_FLAG_BIT]; // R12
		end
		if (st_reg.bpart) begin
			n.rc = 1'b0; // R13
		end

		// Vector prediction; the checks run in the order written.
		c1 = mv_in.left_candidate_vector.vec; // R2
		c2 = mv_in.above_candidate_vector.vec;
		c3 = mv_in.above_right_candidate_vector.vec;
		if (zero_cand(mv_in.left_candidate_vector, mv_in.bidir_pair)) begin
			c1 = '0; // R3
		end
		if (zero_cand(mv_in.above_candidate_vector, mv_in.bidir_pair)) begin
			c2 = '0; // R3
		end
		if (zero_cand(mv_in.above_right_candidate_vector, mv_in.bidir_pair)) begin
			c3 = '0; // R3
		end
		if (mv_in.left_outside) begin
			c1 = '0; // R4
		end
		top_out = mv_in.above_outside_picture ||
			(mv_in.above_outside_group && mv_in.group_header_nonempty) ||
			(mv_in.slice_mode && mv_in.above_outside_slice);
		if (top_out) begin
			c2 = c1; // R5
			c3 = c1; // R5
		end
		if (mv_in.right_outside) begin
			c3 = '0; // R6
		end
		luma.x = mv_wrap(med3(c1.x, c2.x, c3.x), mv_in.vector_difference_code.x); // R1 R7
		luma.y = mv_wrap(med3(c1.y, c2.y, c3.y), mv_in.vector_difference_code.y); // R1 R7
		if (st_reg.mv_out_vld && mv_out_ready) begin
			n.mv_out_vld = 1'b0;
		end
		if (mv_in_valid && st_reg.mv_in_rdy) begin
			// The frame memory adds the vector to the pixel position, so
			// positive values fetch right and below; the same luma vector is
			// used for the four luma blocks.
			n.mv_out_vld = 1'b1; // R24
			n.mv_res.luma = luma; // R8 R9
			n.mv_res.chroma.x = mv_chroma(luma.x); // R10
			n.mv_res.chroma.y = mv_chroma(luma.y); // R10
		end
		n.mv_in_rdy = !n.mv_out_vld;

		// Half-pixel interpolation; the shifts truncate.
		if (ip_in.half_x && ip_in.half_y) begin
			isum = (10'(ip_in.a) + 10'(ip_in.b) + 10'(ip_in.c) + 10'(ip_in.d) + 10'h002 -
				10'(st_reg.rc)) >> 2; // R11 R14
		end else if (ip_in.half_x) begin
			isum = (10'(ip_in.a) + 10'(ip_in.b) + 10'h001 - 10'(st_reg.rc)) >> 1; // R14
		end else if (ip_in.half_y) begin
			isum = (10'(ip_in.a) + 10'(ip_in.c) + 10'h001 - 10'(st_reg.rc)) >> 1; // R14
		end else begin
			isum = 10'(ip_in.a);
		end
		if (st_reg.ip_out_vld && ip_out_ready) begin
			n.ip_out_vld = 1'b0;
		end
		if (ip_in_valid && st_reg.ip_in_rdy) begin
			n.ip_out_vld = 1'b1; // R24
			n.ip_res = isum[7:0];
		end
		n.ip_in_rdy = !n.ip_out_vld;

		// Dequantisation of the offered coefficient.
		mag = 8'(cf_in.level[7] ? -cf_in.level : cf_in.level);
		recm = 14'(cf_in.quantizer_step) * 14'({mag, 1'b1}); // R16
		if (!cf_in.quantizer_step[0]) begin
			recm = recm - 14'h0001; // R16
		end
		recs = cf_in.level[7] ? -$signed({1'b0, recm}) : $signed({1'b0, recm}); // R17
		if (recs > VBR_REC_MAX) begin
			recs = VBR_REC_MAX; // R18
		end else if (recs < VBR_REC_MIN) begin
			recs = VBR_REC_MIN; // R18
		end
		if (cf_in.level == 8'sh00) begin
			recs = '0; // R15
		end
		if (cf_in.is_dc) begin
			recs = 15'(cf_in.intra_dc_coefficient);
		end

		if (st_reg.px_vld && px_out_ready) begin
			n.px_vld = 1'b0;
		end
		case (st_reg.fsm)
			VBR_S_COLLECT: begin
				if (cf_in_valid && st_reg.cf_rdy) begin
					n.coef[raster_of(cf_in.zz_index)] = recs[11:0]; // R19
					n.intra = cf_in.intra;
					if (cf_in.last) begin
						n.fsm = VBR_S_ROWS;
						n.idx = 6'h00;
						n.k = 3'h0;
						n.acc = '0;
					end
				end
			end
			VBR_S_ROWS: begin
				// One multiply per cycle keeps the area small at 512 cycles a pass.
				term = 36'($signed(st_reg.coef[{st_reg.idx[5:3], st_reg.k}]) *
					kern(st_reg.idx[2:0], st_reg.k)); // R20 R21
				accn = st_reg.acc + term;
				n.acc = accn;
				n.k = st_reg.k + 3'h1;
				if (st_reg.k == 3'h7) begin
					scaled = (accn + VBR_P1_ROUND) >>> VBR_P1_SHIFT;
					if (scaled > VBR_TMP_MAX) begin
						scaled = VBR_TMP_MAX;
					end else if (scaled < VBR_TMP_MIN) begin
						scaled = VBR_TMP_MIN;
					end
					n.tmp[st_reg.idx] = scaled[17:0];
					n.acc = '0;
					n.idx = st_reg.idx + 6'h01;
					if (st_reg.idx == 6'h3f) begin
						n.fsm = VBR_S_COLS;
					end
				end
			end
			VBR_S_COLS: begin
				term = 36'($signed(st_reg.tmp[{st_reg.k, st_reg.idx[2:0]}]) *
					kern(st_reg.idx[5:3], st_reg.k)); // R20 R21
				accn = st_reg.acc + term;
				n.acc = accn;
				n.k = st_reg.k + 3'h1;
				if (st_reg.k == 3'h7) begin
					scaled = (accn + VBR_P2_ROUND) >>> VBR_P2_SHIFT;
					if (scaled > VBR_IDCT_MAX) begin
						scaled = VBR_IDCT_MAX; // R20
					end else if (scaled < VBR_IDCT_MIN) begin
						scaled = VBR_IDCT_MIN; // R20
					end
					n.coef[st_reg.idx] = scaled[11:0];
					n.acc = '0;
					n.idx = st_reg.idx + 6'h01;
					if (st_reg.idx == 6'h3f) begin
						n.fsm = VBR_S_OUT;
					end
				end
			end
			VBR_S_OUT: begin
				take = st_reg.intra ? !st_reg.px_vld : (pred_valid && st_reg.pred_rdy);
				psum = 13'($signed(st_reg.coef[st_reg.idx]));
				if (!st_reg.intra) begin
					psum = psum + $signed({5'h00, pred_pixel}); // R22
				end
				if (psum < 13'sh0000) begin
					psum = '0; // R23
				end else if (psum > VBR_PIX_MAX) begin
					psum = VBR_PIX_MAX; // R23
				end
				if (take) begin
					n.px_vld = 1'b1; // R24
					n.px.pixel = psum[7:0];
					n.px.last = (st_reg.idx == 6'h3f);
					n.idx = st_reg.idx + 6'h01;
					if (st_reg.idx == 6'h3f) begin
						n.fsm = VBR_S_COLLECT;
						n.coef = '0;
					end
				end
			end
			default: begin
				n.fsm = VBR_S_COLLECT;
			end
		endcase
		n.cf_rdy = (n.fsm == VBR_S_COLLECT);
		n.pred_rdy = (n.fsm == VBR_S_OUT) && !n.intra && !n.px_vld; // R22
		st_next = n;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0; // R24
			st_reg.pictype <= VBR_PICTYPE_RST;
			st_reg.exttype <= VBR_EXTTYPE_RST;
			st_reg.bpart <= VBR_BPART_RST;
			st_reg.wait_req <= 1'b1;
			st_reg.fsm <= VBR_S_COLLECT;
		end else begin
			st_reg <= st_next;
		end
	end

	assign avs_readdata = st_reg.rdata;
	assign avs_waitrequest = st_reg.wait_req;
	assign mv_in_ready = st_reg.mv_in_rdy;
	assign mv_out_valid = st_reg.mv_out_vld;
	assign mv_out = st_reg.mv_res;
	assign ip_in_ready = st_reg.ip_in_rdy;
	assign ip_out_valid = st_reg.ip_out_vld;
	assign ip_out = st_reg.ip_res;
	assign rounding_control = st_reg.rc;
	assign cf_in_ready = st_reg.cf_rdy;
	assign pred_ready = st_reg.pred_rdy;
	assign px_out_valid = st_reg.px_vld;
	assign px_out = st_reg.px;

	bus_answer_a: assert property (@(posedge clk) disable iff (rst) // R24
		(avs_read && st_reg.wait_req) |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("register answer not one cycle");
	rc_bpart_a: assert property (@(posedge clk) disable iff (rst) // R13
		st_reg.bpart |=> !rounding_control)
		else $error("rounding control not zero in B-part");
	rc_ext_a: assert property (@(posedge clk) disable iff (rst) // R12
		(!st_reg.bpart && st_reg.pictype[8:6] != EXT_FORMAT_CODE) |=> !rounding_control)
		else $error("rounding control set without extended type");
	mv_zero_cand_a: assert property (@(posedge clk) disable iff (rst) // R3
		(mv_in_valid && mv_in_ready && mv_in.left_candidate_vector.mb_not_coded_flag &&
		mv_in.above_candidate_vector.mb_not_coded_flag && !mv_in.right_outside &&
		mv_in.above_right_candidate_vector.mb_not_coded_flag)
		|=> mv_out.luma == $past(mv_in.vector_difference_code))
		else $error("uncoded neighbours not zeroed");
	mv_hold_a: assert property (@(posedge clk) disable iff (rst) // R24
		(mv_out_valid && !mv_out_ready) |=> mv_out_valid && $stable(mv_out))
		else $error("vector result dropped while stalled");
	ip_round_a: assert property (@(posedge clk) disable iff (rst) // R14
		(ip_in_valid && ip_in_ready && ip_in.half_x && !ip_in.half_y &&
		ip_in.a == 8'h00 && ip_in.b == 8'h01)
		|=> ip_out == (rounding_control ? 8'h00 : 8'h01))
		else $error("half sample rounding wrong");
	deq_even_a: assert property (@(posedge clk) disable iff (rst) // R16
		(cf_in_valid && cf_in_ready && !cf_in.is_dc && cf_in.level == 8'sh01 &&
		cf_in.quantizer_step == 5'h02 && cf_in.zz_index == 6'h00)
		|=> st_reg.coef[0] == 12'h005)
		else $error("even quantizer reconstruction wrong");
	deq_clip_a: assert property (@(posedge clk) disable iff (rst) // R18
		(cf_in_valid && cf_in_ready && !cf_in.is_dc && cf_in.level == -8'sh40 &&
		cf_in.quantizer_step == 5'h11 && cf_in.zz_index == 6'h02)
		|=> st_reg.coef[8] == 12'h800)
		else $error("coefficient not saturated");
	rows_end_a: assert property (@(posedge clk) disable iff (rst) // R20
		(st_reg.fsm == VBR_S_ROWS && st_reg.idx == 6'h3f && st_reg.k == 3'h7)
		|=> st_reg.fsm == VBR_S_COLS && st_reg.idx == 6'h00)
		else $error("row pass did not hand over");
	intra_nopred_a: assert property (@(posedge clk) disable iff (rst) // R22
		(st_reg.fsm == VBR_S_OUT && st_reg.intra) |-> !pred_ready)
		else $error("intra block consumed prediction");

endmodule // vbr_recon

// file: design/vbr_pkg.sv
// Package of the block reconstruction path: register map, field positions,
// reset values, arithmetic limits, transform tables and the stream carriers.
// Assumes one clock domain; every stream uses valid and ready.
package vbr_pkg;

	localparam logic [3:0] VBR_OFS_PICTYPE = 4'h0;
	localparam logic [3:0] VBR_OFS_EXTTYPE = 4'h4;
	localparam logic [3:0] VBR_OFS_MODE = 4'h8;
	localparam logic [3:0] VBR_OFS_STATUS = 4'hc;
	localparam int VBR_SRCFMT_LSB = 6;
	localparam int VBR_SRCFMT_W = 3;
	localparam int VBR_ROUNDING_TYPE_FLAG_BIT = 6;
	localparam int VBR_BPART_BIT = 0;
	localparam int VBR_ST_RC_BIT = 0;
	localparam int VBR_ST_BUSY_BIT = 1;
	localparam logic [15:0] VBR_PICTYPE_RST = 16'h0000;
	localparam logic [15:0] VBR_EXTTYPE_RST = 16'h0000;
	localparam logic VBR_BPART_RST = 1'b0;

	localparam logic signed [7:0] VBR_MV_MAX = 8'sh1f;
	localparam logic signed [7:0] VBR_MV_MIN = 8'she0;
	localparam logic signed [7:0] VBR_MV_WRAP = 8'sh40;
	localparam logic signed [14:0] VBR_REC_MAX = 15'sh07ff;
	localparam logic signed [14:0] VBR_REC_MIN = 15'sh7800;
	localparam logic signed [35:0] VBR_IDCT_MAX = 36'sh0000000ff;
	localparam logic signed [35:0] VBR_IDCT_MIN = 36'shfffffff00;
	localparam logic signed [35:0] VBR_TMP_MAX = 36'sh00001ffff;
	localparam logic signed [35:0] VBR_TMP_MIN = 36'shffffe0000;
	localparam logic signed [12:0] VBR_PIX_MAX = 13'sh00ff;
	localparam int VBR_P1_SHIFT = 12;
	localparam int VBR_P2_SHIFT = 16;
	localparam logic signed [35:0] VBR_P1_ROUND = 36'sh000000800;
	localparam logic signed [35:0] VBR_P2_ROUND = 36'sh000008000;

	// Zigzag number minus one for each raster position, row by row.
	localparam logic [0:63][5:0] VBR_ZZ_OF_RASTER = {
		6'h00, 6'h01, 6'h05, 6'h06, 6'h0e, 6'h0f, 6'h1b, 6'h1c,
		6'h02, 6'h04, 6'h07, 6'h0d, 6'h10, 6'h1a, 6'h1d, 6'h2a,
		6'h03, 6'h08, 6'h0c, 6'h11, 6'h19, 6'h1e, 6'h29, 6'h2b,
		6'h09, 6'h0b, 6'h12, 6'h18, 6'h1f, 6'h28, 6'h2c, 6'h35,
		6'h0a, 6'h13, 6'h17, 6'h20, 6'h27, 6'h2d, 6'h34, 6'h36,
		6'h14, 6'h16, 6'h21, 6'h26, 6'h2e, 6'h33, 6'h37, 6'h3c,
		6'h15, 6'h22, 6'h25, 6'h2f, 6'h32, 6'h38, 6'h3b, 6'h3d,
		6'h23, 6'h24, 6'h30, 6'h31, 6'h39, 6'h3a, 6'h3e, 6'h3f};

	// Half of cos(m*pi/16) for m = 0..8, scaled by 2^14.
	localparam logic [0:8][14:0] VBR_COS_HALF = {15'h2000, 15'h1f63, 15'h1d90, 15'h1a9b,
		15'h16a1, 15'h11c7, 15'h0c3f, 15'h063e, 15'h0000};
	localparam logic [14:0] VBR_COS_DC = 15'h16a1;

	typedef struct packed {
		logic signed [6:0] x;
		logic signed [6:0] y;
	} vbr_vec_s;

	typedef struct packed {
		vbr_vec_s vec;
		logic intra;
		logic mb_not_coded_flag;
	} vbr_cand_s;

	typedef struct packed {
		vbr_cand_s left_candidate_vector;
		vbr_cand_s above_candidate_vector;
		vbr_cand_s above_right_candidate_vector;
		logic bidir_pair;
		logic left_outside;
		logic above_outside_picture;
		logic above_outside_group;
		logic group_header_nonempty;
		logic slice_mode;
		logic above_outside_slice;
		logic right_outside;
		vbr_vec_s vector_difference_code;
	} vbr_mv_req_s;

	typedef struct packed {
		vbr_vec_s luma;
		vbr_vec_s chroma;
	} vbr_mv_res_s;

	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] c;
		logic [7:0] d;
		logic half_x;
		logic half_y;
	} vbr_ip_req_s;

	typedef struct packed {
		logic signed [7:0] level;
		logic [4:0] quantizer_step;
		logic [5:0] zz_index;
		logic last;
		logic is_dc;
		logic signed [11:0] intra_dc_coefficient;
		logic intra;
	} vbr_coef_s;

	typedef struct packed {
		logic [7:0] pixel;
		logic last;
	} vbr_pix_s;

	typedef enum logic [3:0] {
		VBR_S_COLLECT = 4'h1,
		VBR_S_ROWS = 4'h2,
		VBR_S_COLS = 4'h4,
		VBR_S_OUT = 4'h8
	} vbr_state_e;

endpackage

// file: testbench/vbr_fmem_model.sv
// Frame memory model: hands prediction pixels to the block on request.
// Assumes the block takes a pixel at an edge where pred_valid and pred_ready are high.
module vbr_fmem_model
	import vbr_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] pred_value,
	input wire logic slow,
	input wire logic pred_ready,
	output logic pred_valid,
	output logic [7:0] pred_pixel
);
	timeunit 1ns;
	timeprecision 1ps;
	logic gap;
	always_ff @(posedge clk) begin
		if (rst) begin
			pred_valid <= 1'b0;
			gap <= 1'b0;
		end else if (pred_valid && pred_ready) begin
			pred_valid <= 1'b0;
			gap <= slow;
		end else begin
			pred_valid <= !gap;
			gap <= 1'b0;
		end
	end
	// Idle data shows the inverse value, so a pixel taken without valid is caught.
	assign pred_pixel = pred_valid ? pred_value : ~pred_value;
endmodule // vbr_fmem_model

// file: testbench/vbr_recon_tb.sv
// Testbench of the reconstruction path: registers, vectors, interpolation, pixels.
// Assumes the frame memory model supplies prediction pixels.
module vbr_recon_tb
	import vbr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, avs_read, avs_write, avs_waitrequest, mv_in_valid, mv_in_ready;
	logic mv_out_valid, ip_in_valid, ip_in_ready, ip_out_valid, rounding_control;
	logic cf_in_valid, cf_in_ready, pred_valid, pred_ready, px_out_valid, slow, out_ready;
	logic [3:0] avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata;
	logic [7:0] ip_out, pred_pixel, pred_value;
	vbr_mv_req_s mv_in;
	vbr_mv_res_s mv_out;
	vbr_ip_req_s ip_in;
	vbr_coef_s cf_in;
	vbr_pix_s px_out;
	int fail_count, comparisons;

	vbr_recon dut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .mv_in_valid, .mv_in,
		.mv_in_ready, .mv_out_valid, .mv_out, .mv_out_ready(out_ready), .ip_in_valid, .ip_in,
		.ip_in_ready, .ip_out_valid, .ip_out, .ip_out_ready(1'b1), .rounding_control,
		.cf_in_valid, .cf_in, .cf_in_ready, .pred_valid, .pred_pixel, .pred_ready,
		.px_out_valid, .px_out, .px_out_ready(1'b1));
	vbr_fmem_model fmem (.clk, .rst, .pred_value, .slow, .pred_ready, .pred_valid,
		.pred_pixel);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// A read compares its data with d; a write sends d.
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= 4'hf;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		if (!wr) check("readdata", avs_readdata, d);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic rc_case(input logic [15:0] fmt, input logic [15:0] ext, input logic bp,
		input logic e);
		bus(1'b1, 4'h0, 32'(fmt));
		bus(1'b1, 4'h4, 32'(ext));
		bus(1'b1, 4'h8, 32'(bp));
		repeat (2) @(posedge clk);
		check("rounding_control", 32'(rounding_control), 32'(e));
		bus(1'b0, 4'hc, 32'(e));
	endtask

	function automatic vbr_cand_s cd(input int x, input int y, input logic i, input logic n);
		return {7'(x), 7'(y), i, n};
	endfunction

	function automatic int chroma(input int v);
		int m;
		m = v < 0 ? -v : v;
		m = (m / 4) * 2 + int'(m % 4 != 0);
		return v < 0 ? -m : m;
	endfunction

	task automatic mv(input vbr_cand_s l, input vbr_cand_s a, input vbr_cand_s ar,
		input logic [7:0] f, input int dx, input int dy, input int ex, input int ey);
		@(posedge clk);
		mv_in <= {l, a, ar, f, 7'(dx), 7'(dy)};
		mv_in_valid <= 1'b1;
		do @(posedge clk); while (mv_in_ready !== 1'b1);
		mv_in_valid <= 1'b0;
		do @(posedge clk); while (mv_out_valid !== 1'b1);
		check("luma_x", 32'(mv_out.luma.x), ex);
		check("luma_y", 32'(mv_out.luma.y), ey);
		check("chroma_x", 32'(mv_out.chroma.x), chroma(ex));
		check("chroma_y", 32'(mv_out.chroma.y), chroma(ey));
	endtask

	task automatic ip(input logic hx, input logic hy, input int rcb, input int a, input int b);
		int e;
		e = !hx && !hy ? a : hx && hy ? (2 * a + 2 * b + 22 - rcb) / 4 :
			hx ? (a + b + 1 - rcb) / 2 : (2 * a + 11 - rcb) / 2;
		@(posedge clk);
		ip_in <= '{8'(a), 8'(b), 8'(a + 10), 8'(b + 10), hx, hy};
		ip_in_valid <= 1'b1;
		do @(posedge clk); while (ip_in_ready !== 1'b1);
		ip_in_valid <= 1'b0;
		do @(posedge clk); while (ip_out_valid !== 1'b1);
		check("sample", 32'(ip_out), e);
	endtask

	task automatic coef(input logic signed [7:0] lv, input logic [4:0] q, input logic [5:0] zz,
		input logic last, input logic intra);
		@(posedge clk);
		cf_in <= '{lv, q, zz, last, 1'b0, 12'sh000, intra};
		cf_in_valid <= 1'b1;
		do @(posedge clk); while (cf_in_ready !== 1'b1);
		cf_in_valid <= 1'b0;
	endtask

	task automatic pix(input logic [7:0] e [8]);
		for (int i = 0; i < 64; i++) begin
			do @(posedge clk); while (px_out_valid !== 1'b1);
			check("pixel", 32'(px_out.pixel), 32'(e[i % 8]));
			check("last", 32'(px_out.last), 32'(i == 63));
		end
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		final_report();
	end

	initial begin
		rst = 1'b1;
		{avs_read, avs_write, mv_in_valid, ip_in_valid, cf_in_valid, slow} = 6'h00;
		out_ready = 1'b1;
		avs_address = 4'h0;
		avs_byteenable = 4'h0;
		avs_writedata = 32'h0;
		mv_in = '0;
		ip_in = '0;
		cf_in = '0;
		pred_value = 8'h80;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		check("rc_reset", 32'(rounding_control), 32'h0);
		bus(1'b0, 4'h0, 32'h0);
		bus(1'b0, 4'h2, 32'h0);
		rc_case(16'h01c0, 16'h0040, 1'b0, 1'b1);
		bus(1'b0, 4'h0, 32'h1c0);
		rc_case(16'h0180, 16'h0040, 1'b0, 1'b0);
		rc_case(16'h01c0, 16'h0000, 1'b0, 1'b0);
		rc_case(16'h01c0, 16'h0040, 1'b1, 1'b0);
		mv(cd(4, -2, 0, 0), cd(6, 3, 0, 0), cd(-1, 10, 0, 0), 8'h00, 3, 1, 7, 4);
		mv(cd(8, 8, 1, 0), cd(6, 6, 0, 0), cd(2, -4, 0, 0), 8'h20, -5, 2, -5, 2);
		mv(cd(8, 8, 1, 0), cd(8, 8, 0, 0), cd(0, 0, 0, 0), 8'h80, 0, 0, 8, 8);
		mv(cd(8, 8, 0, 0), cd(4, 4, 0, 1), cd(6, 6, 0, 0), 8'h40, 0, 0, 0, 0);
		mv(cd(1, 1, 0, 0), cd(5, 5, 0, 0), cd(9, 9, 0, 0), 8'h18, 0, 0, 1, 1);
		mv(cd(1, 1, 0, 0), cd(5, 5, 0, 0), cd(9, 9, 0, 0), 8'h10, 0, 0, 5, 5);
		mv(cd(1, 1, 0, 0), cd(5, 5, 0, 0), cd(9, 9, 0, 0), 8'h06, 0, 0, 1, 1);
		mv(cd(2, 2, 0, 0), cd(6, 6, 0, 0), cd(20, 20, 0, 0), 8'h01, 1, -1, 3, 1);
		mv(cd(30, -30, 0, 0), cd(30, -30, 0, 0), cd(30, -30, 0, 0), 8'h00, 10, -10, -24, 24);
		// A stalled result must stay put until the consumer takes it.
		out_ready <= 1'b0;
		mv(cd(5, 5, 0, 1), cd(6, 6, 0, 1), cd(7, 7, 0, 1), 8'h00, 3, -2, 3, -2);
		out_ready <= 1'b1;
		for (int r = 0; r < 2; r++) begin
			rc_case(16'h01c0, 16'(r * 64), 1'b0, r[0]);
			for (int m = 0; m < 4; m++) begin
				ip(m[0], m[1], r, 10, 13);
			end
			ip(1'b1, 1'b0, r, 0, 1);
		end
		// Slow prediction stalls the summation on every pixel after the first of an inter block.
		slow <= 1'b1;
		coef(8'sd10, 5'd1, 6'd1, 1'b1, 1'b0);
		pix('{8'h84, 8'h83, 8'h82, 8'h81, 8'h7f, 8'h7e, 8'h7d, 8'h7c});
		pred_value <= 8'h64;
		coef(8'sd0, 5'd31, 6'd5, 1'b0, 1'b0);
		coef(8'sd1, 5'd2, 6'd0, 1'b0, 1'b0);
		coef(-8'sd2, 5'd4, 6'd0, 1'b1, 1'b0);
		pix('{8{8'h62}});
		coef(-8'sd64, 5'd17, 6'd2, 1'b0, 1'b1);
		coef(8'sd0, 5'd1, 6'd2, 1'b0, 1'b1);
		coef(8'sd127, 5'd31, 6'd0, 1'b1, 1'b1);
		pix('{8{8'hff}});
		pred_value <= 8'h0a;
		coef(-8'sd100, 5'd31, 6'd0, 1'b1, 1'b0);
		pix('{8{8'h00}});
		final_report();
	end
endmodule // vbr_recon_tb
